// ==== design/sdmr_drop_detect.sv ====
`timescale 1ns/1ps
// ********************************
// drop event detector with re-arm
// ********************************
module sdmr_drop_detect (
   input wire logic mclk_in,
   input wire logic clr_in,
   input wire logic hold_in,
   input wire logic enable_in,
   input wire logic below_in,
   output logic set_out
);
   logic armed_q;
   logic armed_d;

   // one event per excursion below the threshold
   assign set_out = enable_in && below_in && armed_q;

   // re-arm only once the supply has come back above release
   always_comb begin
      armed_d = armed_q;
      if (set_out) begin
         armed_d = 1'b0;
      end else if (!below_in) begin
         armed_d = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (clr_in) begin
         armed_q <= 1'b1;
      end else if (!hold_in) begin
         armed_q <= armed_d;
      end
   end
endmodule : sdmr_drop_detect

// ==== design/sdmr_top.sv ====
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// ********************************
// supply drop monitor register block
// ********************************
module sdmr_top
   import sdmr_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic por_b_in,
   input wire logic dstb_rst_in,
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic supply_below_irq_in,
   input wire logic reset_monitor_active_in,
   input wire logic irq_monitor_active_in,
   input wire logic low_speed_standby_in,
   output logic drop_reset_enable_out,
   output logic [3:0] reset_threshold_code_out,
   output logic drop_irq_enable_out,
   output logic [3:0] irq_threshold_code_out,
   output logic irq_low_power_select_out,
   output logic reset_monitor_run_out,
   output logic irq_out
);

   // ********************************
   // reset scope
   // ********************************
   logic por_rst;
   logic gen_rst;
   logic any_rst;

   // deep standby transition reset holds state instead of clearing it
   assign por_rst = !por_b_in;
   assign gen_rst = !rst_b_in && !dstb_rst_in;
   assign any_rst = !rst_b_in;

   // ********************************
   // state
   // ********************************
   sdmr_bus_t bus_q;
   sdmr_bus_t bus_d;
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   sdmr_ctl_t ctl_q;
   sdmr_ctl_t ctl_d;
   logic lock_q;
   logic lock_d;
   logic cause_q;
   logic cause_d;
   logic run_q;
   logic run_d;
   logic sts_irq_q;
   logic sts_rst_q;

   logic req;
   logic take;
   logic wr_take;
   logic drop_set;
   logic clr_hit;

   // ********************************
   // bus handshake
   // ********************************
   assign req = avs_read_in || avs_write_in;
   // the request is taken on the edge where waitrequest is low
   assign take = req && (bus_q == BUS_ACK);
   assign wr_take = take && avs_write_in;

   // every access answers one cycle after it appears
   always_comb begin
      bus_d = bus_q;
      wait_d = 1'b1;
      case (bus_q)
         BUS_IDLE: begin
            if (req) begin
               bus_d = BUS_ACK;
               wait_d = 1'b0;
            end
         end
         BUS_ACK: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (any_rst) begin
         bus_q <= BUS_IDLE;
         wait_q <= 1'b1;
      end else begin
         bus_q <= bus_d;
         wait_q <= wait_d;
      end
   end

   // ********************************
   // read data
   // ********************************
   // read word is built while waiting so it stands at the taking edge
   always_comb begin
      rdata_d = WORD_ZERO;
      if (avs_address_in == OFS_CTL) begin
         rdata_d[CTL_DRE] = ctl_q.drop_reset_enable;
         rdata_d[CTL_THR_R_HI:CTL_THR_R_LO] = ctl_q.reset_threshold_code;
         rdata_d[CTL_IE] = ctl_q.drop_irq_enable;
         rdata_d[CTL_THR_I_HI:CTL_THR_I_LO] = ctl_q.irq_threshold_code;
         rdata_d[CTL_LPM] = ctl_q.irq_low_power_select;
      end else if (avs_address_in == OFS_CAUSE) begin
         rdata_d[CAUSE_BIT] = cause_q;
      end else if (avs_address_in == OFS_CLR) begin
         rdata_d = CLR_READ;
      end else if (avs_address_in == OFS_LOCK) begin
         rdata_d = lock_q ? LOCK_RD_LOCKED : LOCK_RD_OPEN;
      end else if (avs_address_in == OFS_STATUS) begin
         rdata_d[STS_IRQ_RDY] = sts_irq_q;
         rdata_d[STS_RST_RDY] = sts_rst_q;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (any_rst) begin
         rdata_q <= WORD_ZERO;
      end else if (avs_read_in && bus_q == BUS_IDLE) begin
         rdata_q <= rdata_d;
      end
   end

   // ********************************
   // write lock
   // ********************************
   // any write other than the full key relocks, including partial writes
   always_comb begin
      lock_d = lock_q;
      if (wr_take && avs_address_in == OFS_LOCK) begin
         lock_d = !(avs_byteenable_in == BE_ALL
                    && avs_writedata_in == LOCK_KEY);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (por_rst || gen_rst) begin
         lock_q <= 1'b1;
      end else if (!any_rst) begin
         lock_q <= lock_d;
      end
   end

   // ********************************
   // control register
   // ********************************
   // reserved bits are not stored, so they read zero and ignore writes
   always_comb begin
      ctl_d = ctl_q;
      if (wr_take && avs_address_in == OFS_CTL && !lock_q) begin
         if (avs_byteenable_in[BE_HI]) begin
            ctl_d.drop_reset_enable = avs_writedata_in[CTL_DRE];
            // illegal reset codes leave the old code in place
            if (avs_writedata_in[CTL_THR_R_HI:CTL_THR_R_LO] == THR_R_LOW
                || avs_writedata_in[CTL_THR_R_HI:CTL_THR_R_LO] == THR_R_HIGH) begin
               ctl_d.reset_threshold_code =
                  avs_writedata_in[CTL_THR_R_HI:CTL_THR_R_LO];
            end
         end
         if (avs_byteenable_in[BE_LO]) begin
            ctl_d.drop_irq_enable = avs_writedata_in[CTL_IE];
            if (avs_writedata_in[CTL_THR_I_HI:CTL_THR_I_LO] != THR_I_FORBID) begin
               ctl_d.irq_threshold_code =
                  avs_writedata_in[CTL_THR_I_HI:CTL_THR_I_LO];
            end
            ctl_d.irq_low_power_select = avs_writedata_in[CTL_LPM];
         end
      end
   end

   // upper byte clears only on power-on; lower byte also on any reset other than a deep standby transition reset
   always_ff @(posedge mclk_in) begin
      if (por_rst) begin
         ctl_q <= CTL_RST;
      end else if (gen_rst) begin
         ctl_q.drop_irq_enable <= CTL_RST.drop_irq_enable;
         ctl_q.irq_threshold_code <= CTL_RST.irq_threshold_code;
         ctl_q.irq_low_power_select <= CTL_RST.irq_low_power_select;
      end else if (!any_rst) begin
         ctl_q <= ctl_d;
      end
   end

   // ********************************
   // interrupt cause
   // ********************************
   sdmr_drop_detect u_detect (
      .mclk_in(mclk_in),
      .clr_in(por_rst || gen_rst),
      .hold_in(any_rst),
      .enable_in(ctl_q.drop_irq_enable && irq_monitor_active_in),
      .below_in(supply_below_irq_in),
      .set_out(drop_set)
   );

   assign clr_hit = wr_take && avs_address_in == OFS_CLR
                    && avs_byteenable_in[BE_LO] && !avs_writedata_in[CLR_BIT];

   // a drop in the same cycle as a clear wins, so no event is lost
   always_comb begin
      cause_d = cause_q;
      if (drop_set) begin
         cause_d = 1'b1;
      end else if (clr_hit) begin
         cause_d = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (por_rst || gen_rst) begin
         cause_q <= 1'b0;
      end else if (!any_rst) begin
         cause_q <= cause_d;
      end
   end

   // ********************************
   // reset monitor gating and status
   // ********************************
   // the drop reset is parked in low-speed standby while the irq monitor is enabled in low-power mode
   always_comb begin
      run_d = ctl_q.drop_reset_enable
              && !(ctl_q.drop_irq_enable && ctl_q.irq_low_power_select
                   && low_speed_standby_in);
   end

   always_ff @(posedge mclk_in) begin
      if (por_rst) begin
         run_q <= CTL_RST.drop_reset_enable;
         sts_irq_q <= 1'b0;
         sts_rst_q <= 1'b1;
      end else if (!any_rst) begin
         run_q <= run_d;
         sts_irq_q <= irq_monitor_active_in;
         sts_rst_q <= reset_monitor_active_in;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign drop_reset_enable_out = ctl_q.drop_reset_enable;
   assign reset_threshold_code_out = ctl_q.reset_threshold_code;
   assign drop_irq_enable_out = ctl_q.drop_irq_enable;
   assign irq_threshold_code_out = ctl_q.irq_threshold_code;
   assign irq_low_power_select_out = ctl_q.irq_low_power_select;
   assign reset_monitor_run_out = run_q;
   assign irq_out = cause_q;

   // ********************************
   // checks
   // ********************************
   locked_write_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (wr_take && avs_address_in == OFS_CTL && lock_q) |=> $stable(ctl_q))
      else $error("control changed while locked");

   key_unlock_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (wr_take && avs_address_in == OFS_LOCK && avs_byteenable_in == BE_ALL)
      |=> (lock_q == ($past(avs_writedata_in) != LOCK_KEY)))
      else $error("lock state does not follow written value");

   lock_read_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (avs_read_in && bus_q == BUS_IDLE && avs_address_in == OFS_LOCK)
      ##1 !avs_waitrequest_out
      |-> avs_readdata_out == ($past(lock_q) ? LOCK_RD_LOCKED : LOCK_RD_OPEN))
      else $error("lock read value wrong");

   no_set_off_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (!ctl_q.drop_irq_enable && !cause_q) |=> !cause_q)
      else $error("cause set while interrupt monitor stopped");

   // only a fresh fall is sure to be armed; a level held low after a clear must not set
   drop_sets_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (ctl_q.drop_irq_enable && irq_monitor_active_in && $rose(supply_below_irq_in))
      |=> irq_out)
      else $error("drop did not raise the request");

   clear_cause_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (clr_hit && !drop_set) |=> !irq_out ##1 (irq_out == $past(drop_set)))
      else $error("cause clear misbehaved");

   no_rearm_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (cause_q && clr_hit && !drop_set && supply_below_irq_in)
      ##1 supply_below_irq_in |=> !cause_q)
      else $error("cause set again without release");

   cause_read_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (avs_read_in && bus_q == BUS_IDLE && avs_address_in == OFS_CAUSE)
      |=> avs_readdata_out == {24'h000000, $past(cause_q), 7'h00})
      else $error("cause read value wrong");

   ctl_reserved_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (avs_read_in && bus_q == BUS_IDLE && avs_address_in == OFS_CTL)
      |=> avs_readdata_out[14] == 1'b0 && avs_readdata_out[9:8] == 2'b00
          && avs_readdata_out[0] == 1'b0)
      else $error("reserved control bits not zero");

   lp_park_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (ctl_q.drop_irq_enable && ctl_q.irq_low_power_select
       && low_speed_standby_in) |=> !reset_monitor_run_out)
      else $error("drop reset runs in low-power standby");

   por_scope_a: assert property (
      @(posedge mclk_in) disable iff (por_rst)
      !rst_b_in |=> $stable(ctl_q.drop_reset_enable)
                    && $stable(ctl_q.reset_threshold_code))
      else $error("upper control bits changed by a non power-on reset");

   bus_answer_a: assert property (
      @(posedge mclk_in) disable iff (any_rst)
      (req && bus_q == BUS_IDLE) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer not one cycle");
endmodule : sdmr_top

// ==== inc/sdmr_pkg.sv ====
// Notes on behaviour
// - control bit 15 at 1 enables drop reset, at 0 stops its monitor; resets 1.
// - reset threshold bits 13:10 take only 0001 (default, low) or 0100 (high).
// - control bit 7 enables the drop interrupt monitor when 1; resets to 0.
// - interrupt threshold bits 5:2 take codes 0000..1110, default 0000; 1111 forbidden.
// - control bit 1 selects normal mode at 0 (reset) or low-power mode at 1.
// - control bits 14, 9:8, 0 read zero, bit 6 undefined; writes to them ignored.
// - control register ignores writes while locked; locked after reset until key written; lock_q is kept through a deep standby transition reset.
// - with interrupt enable at 0 the cause flag is never set.
// - enable and low-power both 1 stop the drop reset in low-speed standby modes.
// - control bits 15:8 return to defaults only on power-on reset.
// - control, cause and cause-clear registers survive a deep standby transition reset.
// - cause bit 7 reads 1 once a drop is caught, else 0; bits 6:0 zero.
// - writing 0 to clear bit 7 clears the cause; 1 does nothing; reads 1.
// - with monitoring on, supply below threshold sets the cause and raises the request.
// - unlocked until a non-key value is written; lock reads 1 locked, 0 unlocked.
// - after a clear the cause is not set again until supply rises above release.
package sdmr_pkg;
   // ********************************
   // register map, byte addresses
   // ********************************
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTL = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_CAUSE = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_CLR = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_LOCK = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

   // ********************************
   // lock register values
   // ********************************
   localparam logic [31:0] LOCK_KEY = 32'h1ACCE553;
   localparam logic [31:0] LOCK_RD_LOCKED = 32'h00000001;
   localparam logic [31:0] LOCK_RD_OPEN = 32'h00000000;
   localparam logic [31:0] WORD_ZERO = 32'h00000000;

   // ********************************
   // control register fields
   // ********************************
   localparam int CTL_DRE = 15;
   localparam int CTL_THR_R_HI = 13;
   localparam int CTL_THR_R_LO = 10;
   localparam int CTL_IE = 7;
   localparam int CTL_THR_I_HI = 5;
   localparam int CTL_THR_I_LO = 2;
   localparam int CTL_LPM = 1;
   localparam int BE_HI = 1;
   localparam int BE_LO = 0;
   localparam logic [3:0] BE_ALL = 4'hF;
   localparam logic [3:0] THR_R_LOW = 4'h1;
   localparam logic [3:0] THR_R_HIGH = 4'h4;
   localparam logic [3:0] THR_I_FORBID = 4'hF;
   localparam logic [3:0] THR_I_RST = 4'h0;

   // ********************************
   // cause, clear and status fields
   // ********************************
   localparam int CAUSE_BIT = 7;
   localparam int CLR_BIT = 7;
   localparam int STS_IRQ_RDY = 7;
   localparam int STS_RST_RDY = 6;
   localparam logic [31:0] CLR_READ = 32'h00000080;

   typedef struct packed {
      logic drop_reset_enable;
      logic [3:0] reset_threshold_code;
      logic drop_irq_enable;
      logic [3:0] irq_threshold_code;
      logic irq_low_power_select;
   } sdmr_ctl_t;

   localparam sdmr_ctl_t CTL_RST = '{drop_reset_enable: 1'b1,
                                     reset_threshold_code: THR_R_LOW,
                                     drop_irq_enable: 1'b0,
                                     irq_threshold_code: THR_I_RST,
                                     irq_low_power_select: 1'b0};

   // bus handshake states, one-hot
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } sdmr_bus_t;
endpackage : sdmr_pkg

// ==== verif/sdmr_top_tb_top.sv ====
`timescale 1ns/1ps
module sdmr_top_tb_top;
   import sdmr_pkg::*;
   // ***************************
   // stimulus and observed nets
   // ***************************
   logic mclk_in, rst_b_in, por_b_in, dstb_rst_in;
   logic [ADDR_W-1:0] avs_address_in;
   logic avs_read_in, avs_write_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
   logic [3:0] avs_byteenable_in, reset_threshold_code_out, irq_threshold_code_out;
   logic avs_waitrequest_out, supply_below_irq_in, reset_monitor_active_in;
   logic irq_monitor_active_in, low_speed_standby_in, drop_reset_enable_out;
   logic drop_irq_enable_out, irq_low_power_select_out, reset_monitor_run_out, irq_out;
   int err_count;
   int tests_run;

   sdmr_top u_dut (
      .mclk_in(mclk_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in),
      .dstb_rst_in(dstb_rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .supply_below_irq_in(supply_below_irq_in),
      .reset_monitor_active_in(reset_monitor_active_in),
      .irq_monitor_active_in(irq_monitor_active_in),
      .low_speed_standby_in(low_speed_standby_in),
      .drop_reset_enable_out(drop_reset_enable_out),
      .reset_threshold_code_out(reset_threshold_code_out),
      .drop_irq_enable_out(drop_irq_enable_out),
      .irq_threshold_code_out(irq_threshold_code_out),
      .irq_low_power_select_out(irq_low_power_select_out),
      .reset_monitor_run_out(reset_monitor_run_out), .irq_out(irq_out)
   );

   // 125 MHz clock
   initial begin
      mclk_in = 1'b0;
      forever #4 mclk_in = ~mclk_in;
   end

   // ***************************
   // checking and bus tasks
   // ***************************
   task automatic close_out();
      $display("checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chb(input logic got, input logic exp, input string what);
      chk({31'h0, got}, {31'h0, exp}, what);
   endtask : chb

   // one access; holds the request until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                      input logic [3:0] be);
      int n;
      n = 0;
      avs_address_in <= a;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      avs_writedata_in <= wd;
      avs_byteenable_in <= be;
      @(posedge mclk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 20) begin
         @(posedge mclk_in);
         n++;
      end
      rdata = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      // extra edge so the next call never re-raises in the same step
      @(posedge mclk_in);
      if (n >= 20) begin
         err_count++;
         $display("MISMATCH t=%0t bus access never answered", $time);
         close_out();
      end
   endtask : bus

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      bus(1'b1, a, d, BE_ALL);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, WORD_ZERO, BE_ALL);
      chk(rdata, exp, what);
   endtask : rd

   // analog inputs are levels; allow the detector a few edges to react
   task automatic settle();
      repeat (4) @(posedge mclk_in);
   endtask : settle

   task automatic do_reset(input logic por_b, input logic dstb);
      rst_b_in <= 1'b0;
      por_b_in <= por_b;
      dstb_rst_in <= dstb;
      repeat (3) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      por_b_in <= 1'b1;
      dstb_rst_in <= 1'b0;
      @(posedge mclk_in);
   endtask : do_reset

   // ***************************
   // main sequence
   // ***************************
   initial begin
      err_count = 0;
      tests_run = 0;
      rst_b_in = 1'b0;
      por_b_in = 1'b0;
      dstb_rst_in = 1'b0;
      avs_address_in = '0;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = WORD_ZERO;
      avs_byteenable_in = 4'h0;
      supply_below_irq_in = 1'b0;
      reset_monitor_active_in = 1'b1;
      irq_monitor_active_in = 1'b0;
      low_speed_standby_in = 1'b0;
      @(posedge mclk_in);
      do_reset(1'b0, 1'b0);
      // defaults after power-on
      rd(OFS_CTL, 32'h8400, "ctl reset");
      rd(OFS_LOCK, 32'h1, "lock reset");
      rd(OFS_CAUSE, 32'h0, "cause reset");
      rd(OFS_CLR, 32'h80, "clear reads");
      rd(OFS_STATUS, 32'h40, "status");
      rd(5'h14, 32'h0, "unmapped");
      // locked write has no effect
      wr(OFS_CTL, 32'h0);
      rd(OFS_CTL, 32'h8400, "locked write");
      wr(OFS_LOCK, LOCK_KEY);
      rd(OFS_LOCK, 32'h0, "unlocked");
      wr(OFS_CTL, 32'h0400);
      rd(OFS_CTL, 32'h0400, "stop setting");
      chb(drop_reset_enable_out, 1'h0, "reset enable off");
      // reserved bits written high must read back zero
      wr(OFS_CTL, 32'hD37A);
      rd(OFS_CTL, 32'h903A, "fields");
      chk({28'h0, reset_threshold_code_out}, 32'h4, "reset code");
      chk({28'h0, irq_threshold_code_out}, 32'hE, "irq code");
      chb(irq_low_power_select_out, 1'h1, "low power");
      // forbidden codes leave each field as it was
      wr(OFS_CTL, 32'h8C3E);
      rd(OFS_CTL, 32'h903A, "bad codes");
      wr(OFS_LOCK, WORD_ZERO);
      rd(OFS_LOCK, 32'h1, "relocked");
      wr(OFS_CTL, 32'h0);
      rd(OFS_CTL, 32'h903A, "relocked write");
      // monitor stopped: a drop must not set the cause
      supply_below_irq_in <= 1'b1;
      irq_monitor_active_in <= 1'b1;
      reset_monitor_active_in <= 1'b0;
      settle();
      chb(irq_out, 1'h0, "irq while disabled");
      rd(OFS_CAUSE, 32'h0, "cause while disabled");
      rd(OFS_STATUS, 32'h80, "status flags");
      // clear, then enable with low power in a low-speed standby mode
      wr(OFS_LOCK, LOCK_KEY);
      wr(OFS_CLR, 32'h0);
      supply_below_irq_in <= 1'b0;
      wr(OFS_CTL, 32'h90BA);
      low_speed_standby_in <= 1'b1;
      settle();
      chb(drop_irq_enable_out, 1'h1, "irq enable");
      chb(reset_monitor_run_out, 1'h0, "reset monitor stopped");
      supply_below_irq_in <= 1'b1;
      settle();
      chb(irq_out, 1'h1, "irq on drop");
      rd(OFS_CAUSE, 32'h80, "cause set");
      wr(OFS_CLR, 32'hFF);
      rd(OFS_CAUSE, 32'h80, "clear with one");
      wr(OFS_CLR, 32'h0);
      chb(irq_out, 1'h0, "irq cleared");
      settle();
      rd(OFS_CAUSE, 32'h0, "no re-set while low");
      supply_below_irq_in <= 1'b0;
      settle();
      supply_below_irq_in <= 1'b1;
      settle();
      chb(irq_out, 1'h1, "irq after re-arm");
      // normal mode keeps the reset monitor running
      wr(OFS_CTL, 32'h90B8);
      settle();
      chb(reset_monitor_run_out, 1'h1, "reset monitor normal");
      // deep standby transition reset keeps every register
      do_reset(1'b1, 1'b1);
      rd(OFS_CTL, 32'h90B8, "ctl kept");
      rd(OFS_CAUSE, 32'h80, "cause kept");
      rd(OFS_LOCK, 32'h0, "lock kept");
      // other reset: upper byte kept, lower byte to defaults
      supply_below_irq_in <= 1'b0;
      do_reset(1'b1, 1'b0);
      rd(OFS_CTL, 32'h9000, "ctl after reset");
      rd(OFS_LOCK, 32'h1, "lock after reset");
      rd(OFS_CAUSE, 32'h0, "cause after reset");
      do_reset(1'b0, 1'b0);
      rd(OFS_CTL, 32'h8400, "ctl after power-on");
      // only the lower lane is written
      wr(OFS_LOCK, LOCK_KEY);
      bus(1'b1, OFS_CTL, 32'h0084, 4'h1);
      rd(OFS_CTL, 32'h8484, "lane write");
      // wake source blocked: interrupt enable cleared through the lower lane
      bus(1'b1, OFS_CTL, 32'h0004, 4'h1);
      chb(drop_irq_enable_out, 1'h0, "irq enable off");
      rd(OFS_CTL, 32'h8404, "irq off");
      close_out();
   end
endmodule : sdmr_top_tb_top
